// ---- bench/flash_dev_model.sv ----
`include "flash_ctrl_params.svh"
`default_nettype none
// ------
// behavioural flash device
// ------
module flash_dev_model #(
   parameter bit TOP_BOOT = 1'b1  // boot block at the top end
)(
   input  wire logic [18:0] addr,
   input  wire logic        sel_n,
   input  wire logic        gate_n,
   input  wire logic        wstrobe_n,
   input  wire logic        protect_n,
   input  wire logic [15:0] dq_wire,
   output logic      [15:0] dq_dev
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [logic [18:0]];  // absent words read erased
   int          busy_ns = 300;       // raised by the bench for slow answers
   int          viol = 0;            // host faults seen on the pins
   int          step = 0;            // unlock progress
   logic        busy = 1'b0;
   logic        is_prog = 1'b0;
   logic        tog = 1'b0;
   logic [15:0] last = 16'h0000;     // released bus shows its inverse
   logic [15:0] prog_d;
   logic [18:0] lat_a;
   logic        moved = 1'b0;        // address or select moved since power-up
   logic        low_power = 1'b0;    // near-standby after a finished read
   wire logic   wr_act = !sel_n && !wstrobe_n && gate_n;
   wire logic   rd_act = !sel_n && !gate_n;

   function automatic logic [15:0] word(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction : word

   function automatic logic [18:0] mask(input logic blk, input logic [18:0] t);
      if (!blk)
         return 19'h7_F800;
      return t >= 19'h7_E000 ? 19'h7_E000 : t >= 19'h7_C000 ? 19'h7_F000
           : t >= 19'h7_8000 ? 19'h7_C000 : 19'h7_8000;
   endfunction : mask

   task automatic go_busy(input logic prog, input logic [15:0] d);
      busy = 1'b1;
      is_prog = prog;
      prog_d = d;
      fork
         #(busy_ns) busy = 1'b0;
      join_none
   endtask : go_busy

   task automatic command(input logic [18:0] a, input logic [15:0] d);
      logic [18:0] t;
      logic [18:0] m;
      logic [18:0] k [$];
      t = TOP_BOOT ? a : ~a;
      if (step == 6)
      begin
         if (word(a) !== 16'hFFFF)
            viol++;
         mem[a] = word(a) & d;
         go_busy(1'b1, d);
         step = 0;
      end
      else if (step == 5)
      begin
         m = mask(d === `FC_CMD_BLOCK, t);
         step = 0;
         if ((d === `FC_CMD_BLOCK || d === `FC_CMD_SECTOR) && !(!protect_n && t >= 19'h7_E000))
         begin
            foreach (mem[i])
               if ((i & m) == (a & m))
                  k.push_back(i);
            foreach (k[j])
               mem.delete(k[j]);
            go_busy(1'b0, d);
         end
      end
      else if (step == 0 || step == 3)
         step = (a === `FC_UNLOCK_A1 && d === `FC_UNLOCK_D1) ? step + 1 : 0;
      else if (step == 1 || step == 4)
         step = (a === `FC_UNLOCK_A2 && d === `FC_UNLOCK_D2) ? step + 1 : 0;
      else
         step = a !== `FC_UNLOCK_A1 ? 0 : d === `FC_CMD_PROGRAM ? 6
              : d === `FC_CMD_ERASE_PRE ? 3 : 0;
   endtask : command

   // address at the later falling edge
   always @(posedge wr_act)
      lat_a = addr;
   // data at the earlier rising edge, dropped while busy
   always @(negedge wr_act)
      if (!busy)
         command(lat_a, dq_wire);
   // status bit six flips per read
   always @(negedge gate_n)
      if (!sel_n && busy)
         tog = ~tog;
   // no near-standby until the address moves or select rises
   always @(addr or posedge sel_n)
      moved = 1'b1;
   // near-standby once a read ends, left again when the next read starts
   always @(negedge rd_act)
      low_power = moved;
   always @(posedge rd_act)
      low_power = 1'b0;
   // word or status only when selected and gated, otherwise the inverse of the last read word
   always @*
      if (rd_act && busy)
         dq_dev = {8'h00, is_prog ? ~prog_d[7] : 1'b0, tog, 6'h00};
      else if (rd_act)
         dq_dev = word(addr);
      else
         dq_dev = ~last;
   always @(dq_dev)
      if (rd_act)
         last = dq_dev;
   always @(negedge wstrobe_n)
      if (sel_n !== 1'b0)
         viol++;
   always @(protect_n)
      if (step != 0)
         viol++;
endmodule : flash_dev_model
`default_nettype wire

// ---- bench/testbench.sv ----
`include "flash_ctrl_params.svh"
`default_nettype none
module testbench
   import flash_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        req_valid = 1'b0;
   logic [1:0]  req_op = 2'h0;
   logic [18:0] req_addr = 19'h0_0000;
   logic [15:0] req_data = 16'h0000;
   logic        protect_in = 1'b0;
   logic        req_ready, rsp_valid, rsp_error, fl_sel_n, fl_gate_n;
   logic        fl_wstrobe_n, fl_protect_n, fl_dq_oe_n;
   logic [15:0] rsp_data, fl_dq_out, dq_dev, dq_wire;
   logic [18:0] fl_addr;
   logic [31:0] seed = 32'h0000_0062;  // xorshift state
   int          failures = 0;
   int          n_tests = 0;
   logic [15:0] d;
   logic [18:0] a;
   // host drives the bus only with its enable low
   assign dq_wire = fl_dq_oe_n ? dq_dev : fl_dq_out;
   always #10 clk = ~clk;

   flash_host_ctrl #(.POLL_MAX(8)) u_dut (
      .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .protect_in(protect_in),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_error(rsp_error), .fl_addr(fl_addr), .fl_sel_n(fl_sel_n),
      .fl_gate_n(fl_gate_n), .fl_wstrobe_n(fl_wstrobe_n), .fl_protect_n(fl_protect_n),
      .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_in(dq_wire));
   flash_dev_model #(.TOP_BOOT(1'b1)) u_dev (
      .addr(fl_addr), .sel_n(fl_sel_n), .gate_n(fl_gate_n), .wstrobe_n(fl_wstrobe_n),
      .protect_n(fl_protect_n), .dq_wire(dq_wire), .dq_dev(dq_dev));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // one request, bounded waits for ready and answer
   task automatic do_req(input logic [1:0] op, input logic [18:0] ra, input logic [15:0] rd);
      int i;
      for (i = 0; i < 50 && req_ready !== 1'b1; i++)
         @(negedge clk);
      if (req_ready !== 1'b1)
      begin
         failures++;
         tally_and_finish();
      end
      req_valid = 1'b1;
      req_op = op;
      req_addr = ra;
      req_data = rd;
      @(negedge clk);
      req_valid = 1'b0;
      for (i = i; i < 4000 && rsp_valid !== 1'b1; i++)
         @(negedge clk);
      if (i >= 4000)
      begin
         failures++;
         tally_and_finish();
      end
   endtask : do_req

   task automatic rd_chk(input logic [18:0] ra, input logic [15:0] exp);
      do_req(OP_READ, ra, 16'h0000);
      check("read data", 32'(rsp_data), 32'(exp));
   endtask : rd_chk

   task automatic prog(input logic [18:0] pa, input logic [15:0] pd);
      do_req(OP_PROG, pa, pd);
      check("program error", 32'(rsp_error), 32'h0000_0000);
   endtask : prog

   initial
   begin
      repeat (10) @(negedge clk);
      check("ready in reset", 32'(req_ready), 32'h0000_0000);
      check("select in reset", 32'(fl_sel_n), 32'h0000_0001);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      // random words written and read back
      for (int i = 0; i < 3; i++)
      begin
         d = 16'(xs());
         a = {3'(i), 16'(xs())};
         rd_chk(a, 16'hFFFF);
         prog(a, d);
         rd_chk(a, d);
         check("low power", 32'(u_dev.low_power), 32'h0000_0001);
      end
      prog(19'h3_0FFF, 16'h1234);
      prog(19'h3_1000, 16'h5678);
      prog(19'h3_07FF, 16'h9ABC);
      do_req(OP_SECTOR, {8'h61, 11'(xs())}, 16'h0000);
      rd_chk(19'h3_0FFF, 16'hFFFF);
      rd_chk(19'h3_1000, 16'h5678);
      rd_chk(19'h3_07FF, 16'h9ABC);
      // block erase, plain and boot area
      prog(19'h5_7FFF, 16'h1111);
      prog(19'h5_8000, 16'h2222);
      prog(19'h7_C000, 16'h4444);
      prog(19'h7_D000, 16'h5555);
      do_req(OP_BLOCK, {4'hA, 15'(xs())}, 16'h0000);
      do_req(OP_BLOCK, 19'h7_C123, 16'h0000);
      rd_chk(19'h5_7FFF, 16'hFFFF);
      rd_chk(19'h5_8000, 16'h2222);
      rd_chk(19'h7_C000, 16'hFFFF);
      rd_chk(19'h7_D000, 16'h5555);
      prog(19'h7_E010, 16'h6666);
      protect_in = 1'b1;
      do_req(OP_BLOCK, 19'h7_E000, 16'h0000);
      do_req(OP_SECTOR, 19'h7_E010, 16'h0000);
      rd_chk(19'h7_E010, 16'h6666);
      protect_in = 1'b0;
      do_req(OP_BLOCK, 19'h7_F555, 16'h0000);
      rd_chk(19'h7_E010, 16'hFFFF);
      u_dev.busy_ns = 9000;
      do_req(OP_PROG, 19'h6_0000, 16'h00A5);
      check("poll limit", 32'(rsp_error), 32'h0000_0001);
      check("inverted bit", 32'(rsp_data[7]), 32'h0000_0000);
      do_req(OP_PROG, 19'h6_1000, 16'h0042);
      repeat (500) @(negedge clk);
      u_dev.busy_ns = 300;
      rd_chk(19'h6_0000, 16'h00A5);
      rd_chk(19'h6_1000, 16'hFFFF);
      check("host faults", 32'(u_dev.viol), 32'h0000_0000);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire

// ---- design/flash_bus_cycle.sv ----
`include "flash_ctrl_params.svh"
`default_nettype none
// ----------------------------------------
// one asynchronous bus cycle: write or read
// ----------------------------------------
module flash_bus_cycle
   import flash_ctrl_pkg::*;
#(
   parameter int SETUP_CYC  = (`FC_SETUP_NS * `FC_CLK_MHZ + 999) / 1000,
   parameter int STROBE_CYC = (`FC_STROBE_NS * `FC_CLK_MHZ + 999) / 1000,
   parameter int READ_CYC   = (`FC_READ_NS * `FC_CLK_MHZ + 999) / 1000
)(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  start,
   input  wire logic                  is_write,
   output logic                       busy,
   output logic                       done,
   output logic                       sel_n,
   output logic                       gate_n,
   output logic                       wstrobe_n,
   output logic                       dq_oe_n,
   output logic                       capture
);
   phase_t     ph_r,  ph_nxt;     // cycle phase
   logic [7:0] cnt_r, cnt_nxt;    // phase timer
   logic       wr_r,  wr_nxt;     // write flag
   // phase sequencing
   always_comb
   begin
      ph_nxt  = ph_r;
      cnt_nxt = (cnt_r == 8'h00) ? 8'h00 : cnt_r - 8'h01;
      wr_nxt  = wr_r;
      case (ph_r)
         PH_IDLE:
         begin
            if (start)
            begin
               wr_nxt  = is_write;
               ph_nxt  = PH_SETUP;
               cnt_nxt = 8'(SETUP_CYC - 1);
            end
         end
         PH_SETUP:
            if (cnt_r == 8'h00)
            begin
               ph_nxt  = PH_STROBE;
               cnt_nxt = wr_r ? 8'(STROBE_CYC - 1) : 8'(READ_CYC - 1);
            end
         PH_STROBE:
            if (cnt_r == 8'h00)
               ph_nxt = PH_HOLD;
         PH_HOLD:
            ph_nxt = PH_IDLE;
         default:
            ph_nxt = PH_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ph_r  <= PH_IDLE;
         cnt_r <= 8'h00;
         wr_r  <= 1'b0;
      end
      else
      begin
         ph_r  <= ph_nxt;
         cnt_r <= cnt_nxt;
         wr_r  <= wr_nxt;
      end
   end
   // pin outputs registered; select low through setup and strobe, high again in hold
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_n     <= 1'b1;
         gate_n    <= 1'b1;
         wstrobe_n <= 1'b1;
         dq_oe_n   <= 1'b1;
         busy      <= 1'b0;
         done      <= 1'b0;
         capture   <= 1'b0;
      end
      else
      begin
         sel_n     <= !(ph_nxt == PH_SETUP || ph_nxt == PH_STROBE);
         wstrobe_n <= !(ph_nxt == PH_STROBE && wr_nxt);
         gate_n    <= !(ph_nxt == PH_STROBE && !wr_nxt);
         // data held through hold phase past strobe rise
         dq_oe_n   <= !(ph_nxt != PH_IDLE && wr_nxt);
         busy      <= (ph_nxt != PH_IDLE);
         done      <= (ph_r == PH_HOLD);
         capture   <= (ph_r == PH_STROBE && cnt_r == 8'h00 && !wr_r);
      end
   end
   a_strobe_in_sel: assert property (@(posedge clk) disable iff (!resetn)
      !wstrobe_n |-> !sel_n) else $error("write strobe outside select");
   a_gate_vs_drive: assert property (@(posedge clk) disable iff (!resetn)
      !gate_n |-> dq_oe_n) else $error("gate and drive together");
endmodule : flash_bus_cycle
`default_nettype wire

// ---- design/flash_host_ctrl.sv ----
`include "flash_ctrl_params.svh"
`default_nettype none
module flash_host_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter int ADDR_W   = `FC_ADDR_W,
   parameter int DATA_W   = `FC_DATA_W,
   parameter int POLL_MAX = 64  // status reads before timeout
)(
   input  wire logic              clk,
   input  wire logic              resetn,
   // user request side
   input  wire logic              req_valid,
   input  wire logic [1:0]        req_op,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_data,
   input  wire logic              protect_in,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   rsp_error,
   // flash pins
   output logic [ADDR_W-1:0]      fl_addr,
   output logic                   fl_sel_n,
   output logic                   fl_gate_n,
   output logic                   fl_wstrobe_n,
   output logic                   fl_protect_n,
   output logic [DATA_W-1:0]      fl_dq_out,
   output logic                   fl_dq_oe_n,
   input  wire logic [DATA_W-1:0] fl_dq_in
);
   // ----------------------------------------
   // command sequence table
   // ----------------------------------------
   // returns address/data of step k of the operation
   function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
      input op_t op, input logic [2:0] k,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [ADDR_W-1:0] ma;
      // sector address bits only
      // block erase keeps the whole address: the boot-end blocks are narrower
      // than 32K, so cutting at bit 15 would aim at the wrong block; the
      // device drops the low bits itself
      ma = (op == OP_SECTOR) ? {a[ADDR_W-1:`FC_SECTOR_LSB], {`FC_SECTOR_LSB{1'b0}}}
                             : a;
      case (k)
         3'd0: seq_word = {ADDR_W'(`FC_UNLOCK_A1), DATA_W'(`FC_UNLOCK_D1)};
         3'd1: seq_word = {ADDR_W'(`FC_UNLOCK_A2), DATA_W'(`FC_UNLOCK_D2)};
         3'd2: seq_word = {ADDR_W'(`FC_UNLOCK_A1),
                  (op == OP_PROG) ? DATA_W'(`FC_CMD_PROGRAM) : DATA_W'(`FC_CMD_ERASE_PRE)};
         // a single word per program request
         3'd3: seq_word = (op == OP_PROG) ? {a, d}
                  : {ADDR_W'(`FC_UNLOCK_A1), DATA_W'(`FC_UNLOCK_D1)};
         3'd4: seq_word = {ADDR_W'(`FC_UNLOCK_A2), DATA_W'(`FC_UNLOCK_D2)};
         default: seq_word = {ma, (op == OP_SECTOR) ? DATA_W'(`FC_CMD_SECTOR)
                                                    : DATA_W'(`FC_CMD_BLOCK)};
      endcase
   endfunction : seq_word
   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t            st_r,   st_nxt;    // controller state
   op_t               op_r,   op_nxt;    // current operation
   logic [2:0]        step_r, step_nxt;  // command cycle index
   logic [ADDR_W-1:0] a_r,    a_nxt;     // user address
   logic [DATA_W-1:0] d_r,    d_nxt;     // user data
   logic [DATA_W-1:0] prev_r, prev_nxt;  // last status read
   logic              first_r, first_nxt;// no previous poll yet
   logic [7:0]        pc_r,   pc_nxt;    // poll count
   logic              go;                 // start a bus cycle
   logic              go_wr;              // that cycle writes
   logic              cyc_done, cyc_busy, cap;
   logic [ADDR_W+DATA_W-1:0] sw;          // current step word
   logic [DATA_W-1:0] smp_r, smp2_r;      // pin input synchroniser
   logic              is_rd;
   logic              go_pend_r;          // go issued last clock, busy not yet seen
   logic [DATA_W-1:0] rd_word_r;          // read word held at the capture strobe
   assign sw    = seq_word(op_r, step_r, a_r, d_r);
   assign is_rd = (st_r == ST_READ) || (st_r == ST_POLL);
   // ----------------------------------------
   // bus cycle engine
   // ----------------------------------------
   flash_bus_cycle u_cyc (
      .clk       (clk),
      .resetn    (resetn),
      .start     (go),
      .is_write  (go_wr),
      .busy      (cyc_busy),
      .done      (cyc_done),
      .sel_n     (fl_sel_n),
      .gate_n    (fl_gate_n),
      .wstrobe_n (fl_wstrobe_n),
      .dq_oe_n   (fl_dq_oe_n),
      .capture   (cap)
   );
   // data pins: read data crosses two flops, capture lines up after
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         smp_r     <= '0;
         smp2_r    <= '0;
         rd_word_r <= '0;
      end
      else
      begin
         smp_r  <= fl_dq_in;
         smp2_r <= smp_r;
         // take the word while the gate is still low, not after release
         if (cap)
            rd_word_r <= smp2_r;
      end
   end
   // ----------------------------------------
   // sequencing; capture arrives one clock before done
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r; op_nxt = op_r; step_nxt = step_r;
      a_nxt = a_r; d_nxt = d_r; prev_nxt = prev_r;
      first_nxt = first_r; pc_nxt = pc_r;
      go = 1'b0; go_wr = 1'b0;
      case (st_r)
         ST_IDLE:
            if (req_valid)
            begin
               op_nxt = op_t'(req_op); a_nxt = req_addr; d_nxt = req_data;
               step_nxt = 3'd0; first_nxt = 1'b1; pc_nxt = 8'h00;
               st_nxt = (op_t'(req_op) == OP_READ) ? ST_READ : ST_CYCLE;
            end
         // unlock then command
         // done shows with busy already low, so it is looked at first
         ST_CYCLE:
            if (cyc_done)
            begin
               if ((op_r == OP_PROG && step_r == 3'd3) || step_r == 3'd5)
                  st_nxt = ST_POLL;
               else
                  step_nxt = step_r + 3'd1;
            end
            else if (!cyc_busy && !go_pend_r)
            begin
               go = 1'b1; go_wr = 1'b1;
            end
         ST_READ, ST_POLL:
            if (cyc_done)
            begin
               prev_nxt = rd_word_r; first_nxt = 1'b0; pc_nxt = pc_r + 8'h01;
               // completion when bit six stops toggling
               // limit: POLL_MAX reads at most, the last one leaves pc_r at POLL_MAX
               if (st_r == ST_READ
                   || (!first_r && rd_word_r[`FC_TOGGLE_BIT] == prev_r[`FC_TOGGLE_BIT])
                   || pc_r == 8'(POLL_MAX - 1))
                  st_nxt = ST_DONE;
            end
            else if (!cyc_busy && !go_pend_r)
               go = 1'b1;
         ST_DONE:
            st_nxt = ST_IDLE;
         default:
            st_nxt = ST_IDLE;
      endcase
   end
   // go is held off for one clock after a cycle starts, until busy shows
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= ST_IDLE; op_r <= OP_READ; step_r <= 3'd0;
         a_r <= '0; d_r <= '0; prev_r <= '0; first_r <= 1'b1; pc_r <= 8'h00;
         go_pend_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt; op_r <= op_nxt; step_r <= step_nxt;
         a_r <= a_nxt; d_r <= d_nxt; prev_r <= prev_nxt;
         first_r <= first_nxt; pc_r <= pc_nxt;
         go_pend_r <= go;
      end
   end
   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fl_addr <= '0; fl_dq_out <= '0; fl_protect_n <= 1'b1;
         req_ready <= 1'b0; rsp_valid <= 1'b0; rsp_data <= '0; rsp_error <= 1'b0;
      end
      else
      begin
         if (st_r == ST_IDLE)
            fl_protect_n <= !protect_in;
         fl_addr   <= is_rd ? a_r : sw[ADDR_W+DATA_W-1:DATA_W];
         fl_dq_out <= sw[DATA_W-1:0];
         req_ready <= (st_nxt == ST_IDLE);
         rsp_valid <= (st_r == ST_DONE);
         rsp_data  <= prev_r;
         rsp_error <= (st_r == ST_DONE) && (op_r != OP_READ) && (pc_r == 8'(POLL_MAX));
      end
   end
   // no new command cycle while device busy polling
   a_no_cmd_poll: assert property (@(posedge clk) disable iff (!resetn)
      st_r == ST_POLL |-> fl_wstrobe_n) else $error("write during poll");
   a_prog_steps: assert property (@(posedge clk) disable iff (!resetn)
      (st_r == ST_CYCLE && op_r == OP_PROG) |-> step_r <= 3'd3)
      else $error("program sequence too long");
   a_protect_hold: assert property (@(posedge clk) disable iff (!resetn)
      (st_r != ST_IDLE && $past(st_r) != ST_IDLE) |-> $stable(fl_protect_n))
      else $error("protect changed mid sequence");
   a_rsp_done: assert property (@(posedge clk) disable iff (!resetn)
      rsp_valid |-> $past(st_r) == ST_DONE) else $error("stray response");
endmodule : flash_host_ctrl
`default_nettype wire

// ---- shared/flash_ctrl_params.svh ----
// What this block does
// - command cycle: strobe low while select low
// - program one word into erased sector only (not checked by the controller, which programs any address given)
// - program: two unlock cycles, command cycle, then address/data
// - hold boot protect steady during sequence
// - sector erase: six cycles, code last
// - block erase: six cycles, code last
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define FC_ADDR_W        19
`define FC_DATA_W        16
`define FC_SECTOR_LSB    11
`define FC_BLOCK_LSB     15
`define FC_POLL_BIT      7
`define FC_TOGGLE_BIT    6
// ----------------------------------------
// unlock sequence, held configurable
// ----------------------------------------
`define FC_UNLOCK_A1     19'h0_0555
`define FC_UNLOCK_D1     16'h00AA
`define FC_UNLOCK_A2     19'h0_02AA
`define FC_UNLOCK_D2     16'h0055
`define FC_CMD_PROGRAM   16'h00A0
`define FC_CMD_ERASE_PRE 16'h0080
`define FC_CMD_SECTOR    16'h0050
`define FC_CMD_BLOCK     16'h0030
// ----------------------------------------
// timing, 50 MHz clock
// ----------------------------------------
`define FC_CLK_MHZ       50
`define FC_SETUP_NS      40
`define FC_STROBE_NS     60
`define FC_READ_NS       80
`define FC_PROG_MAX_NS   10000
`endif

// ---- shared/flash_ctrl_pkg.sv ----
`default_nettype none
package flash_ctrl_pkg;
   // host operation codes
   typedef enum logic [1:0] {
      OP_READ   = 2'h0,
      OP_PROG   = 2'h1,
      OP_SECTOR = 2'h2,
      OP_BLOCK  = 2'h3
   } op_t;
   // main controller states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_CYCLE = 5'h02,
      ST_READ  = 5'h04,
      ST_POLL  = 5'h08,
      ST_DONE  = 5'h10
   } state_t;
   // one bus cycle phases, one-hot
   typedef enum logic [3:0] {
      PH_IDLE   = 4'h1,
      PH_SETUP  = 4'h2,
      PH_STROBE = 4'h4,
      PH_HOLD   = 4'h8
   } phase_t;
endpackage : flash_ctrl_pkg
`default_nettype wire
